// >>> hw/char_shift_defs.svh
// Constants for the character shift register control block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef CHAR_SHIFT_DEFS_SVH
`define CHAR_SHIFT_DEFS_SVH

// Register byte offsets on the Wishbone slave
`define REG_CTRL        8'h00
`define REG_DIVISOR     8'h04
`define REG_STATUS      8'h08
`define ADR_W           8

// Reset values
`define CTRL_RST        32'h0000_0001
`define DIVISOR_RST     16'h0001

// Data register geometry
`define STAGES          11
`define LAST_STAGE      10
`define NEXT_LAST       9
`define HALF_LO         5
`define LFSR_TAP        8
`define MIN_WIDTH       5

// Steps of the hundred-step bit subdivision counter
`define BIT_STEPS       7'h64
`define STEP_TRUE       7'h00
`define STEP_EARLY      7'h01
`define STEP_LOAD       7'h02
`define STEP_MID        7'h32

// Status word layout
`define ST_RUN          31
`define ST_LOAD_REQ     30
`define ST_LAST_MARK    29

`endif

// >>> hw/char_shift_pkg.sv
// Types shared by the character shift register control block.
// Assumes the defines header is on the include path.
`include "char_shift_defs.svh"

package char_shift_pkg;

  // Operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_FREE_RUN  = 6'h01,
    MODE_CHAR_STEP = 6'h02,
    MODE_SEQ_STEP  = 6'h04,
    MODE_SYNC      = 6'h08,
    MODE_RANDOM    = 6'h10,
    MODE_REVERSALS = 6'h20
  } mode_type;

  // Stop mark length selections
  typedef enum logic [1:0] {
    STOP_1_0 = 2'h0,
    STOP_1_5 = 2'h1,
    STOP_2_0 = 2'h2
  } stop_type;

  // Control word as stored at the control offset
  typedef struct packed {
    logic [12:0] reserved;
    logic [6:0]  distort_count;
    logic        distort_en;
    logic [1:0]  width_sel;
    stop_type    stop_sel;
    logic        ext_bit_sync;
    mode_type    mode;
  } ctrl_type;

  // Timing events decoded from the bit subdivision counter
  typedef struct packed {
    logic true_shift;
    logic displaced_shift;
    logic early;
    logic load;
    logic mid_bit;
  } tick_type;

endpackage

// >>> hw/character_shift_register_control.sv
// Character serializer: 11-stage data register, load handshake, last-mark
// detection, half-stop reset, random/reversal feedback, run control,
// time base and hundred-step bit subdivision counter.
// Assumes a classic Wishbone master, synchronous inputs on clk_i and a
// character source that presents the next character on char_data_i.
`include "char_shift_defs.svh"

module character_shift_register_control (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_step_clk_i,
  input  wire logic        step_button_i,
  input  wire logic        ext_step_i,
  input  wire logic        char_end_i,
  input  wire logic [7:0]  char_data_i,
  output logic             serial_o,
  output logic             shift_pulse_o,
  output logic             load_strobe_o,
  output logic             last_mark_flag_o,
  output logic             half_stop_reset_o,
  output logic             run_control_o,
  output logic             run_control_n_o,
  output logic             timebase_o
);

  char_shift_pkg::ctrl_type ctrl;
  logic [15:0]              divisor;
  logic [15:0]              div_cnt;
  logic                     tb_ff;
  logic [6:0]               step_cnt;
  logic [`STAGES-1:0]       sreg;
  logic                     load_request;
  logic                     run_control;
  logic                     rev_phase;
  char_shift_pkg::tick_type tick;
  logic                     step_tick;
  logic                     shift_pulse;
  logic                     ss_mode;
  logic                     sync_mode;
  logic                     rand_mode;
  logic                     rev_mode;
  logic                     free_mode;
  logic                     all_space;
  logic                     last_mark;
  logic                     load_strobe;
  logic                     half_stop_reset;
  logic                     wb_req;
  logic [31:0]              status_word;
  logic [`STAGES-1:0]       next_sreg;
  logic [`STAGES-1:0]       char_vec;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Character image: start Space in the last stage, data after it, then
  // stop Marks or, for synchronous, one indicator Mark
  function automatic logic [`STAGES-1:0] build_char(
      input logic [7:0] d,
      input logic [1:0] wsel,
      input logic       two_stop,
      input logic       sync);
    logic [`STAGES-1:0] v;
    int                 n;
    v = '0;
    n = int'(wsel) + `MIN_WIDTH;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        v[`NEXT_LAST - i] = d[i];
      end
    end
    v[`NEXT_LAST - n] = 1'b1;
    if (!sync && two_stop) begin
      v[`NEXT_LAST - n - 1] = 1'b1;
    end
    return v;
  endfunction

  // Mode decode; an unknown code behaves as free-run
  always_comb begin
    ss_mode   = 1'b0;
    sync_mode = 1'b0;
    rand_mode = 1'b0;
    rev_mode  = 1'b0;
    free_mode = 1'b0;
    case (ctrl.mode)
      char_shift_pkg::MODE_FREE_RUN: begin
        ss_mode   = 1'b1;
        free_mode = 1'b1;
      end
      char_shift_pkg::MODE_CHAR_STEP,
      char_shift_pkg::MODE_SEQ_STEP: begin
        ss_mode = 1'b1;
      end
      char_shift_pkg::MODE_SYNC: begin
        sync_mode = 1'b1;
        free_mode = 1'b1;
      end
      char_shift_pkg::MODE_RANDOM: begin
        rand_mode = 1'b1;
        free_mode = 1'b1;
      end
      char_shift_pkg::MODE_REVERSALS: begin
        rev_mode  = 1'b1;
        free_mode = 1'b1;
      end
      default: begin
        ss_mode   = 1'b1;
        free_mode = 1'b1;
      end
    endcase
  end

  // Wishbone slave: one wait state, ack drops after one cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
    end
  end

  // Control and divisor registers; writes land with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl    <= char_shift_pkg::ctrl_type'(`CTRL_RST);
      divisor <= `DIVISOR_RST;
    end else if (ce_i && wb_req && wb_we_i) begin
      if (wb_adr_i == `REG_CTRL) begin
        ctrl <= char_shift_pkg::ctrl_type'(
                  merge_bytes(32'(ctrl), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == `REG_DIVISOR) begin
        divisor <= 16'(merge_bytes({16'h0000, divisor}, wb_dat_i,
                                   wb_sel_i));
      end
    end
  end

  assign status_word = {run_control, load_request, last_mark,
                        18'h00000, sreg};

  // Read data registered; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i && wb_req) begin
      case (wb_adr_i)
        `REG_CTRL:    wb_dat_o <= 32'(ctrl);
        `REG_DIVISOR: wb_dat_o <= {16'h0000, divisor};
        `REG_STATUS:  wb_dat_o <= status_word;
        default:      wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Time base: divider chain and output flip-flop, stopped by run control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 16'h0000;
      tb_ff   <= 1'b1;
    end else if (ce_i) begin
      if (!run_control) begin
        div_cnt <= 16'h0000;
        tb_ff   <= 1'b1;
      end else if (div_cnt + 16'h0001 >= divisor) begin
        div_cnt <= 16'h0000;
        tb_ff   <= !tb_ff;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

  // One step of the hundred-step counter per output flip-flop rise
  assign step_tick = run_control && !tb_ff &&
                     (div_cnt + 16'h0001 >= divisor);

  // Events decoded from the subdivision count
  always_comb begin
    tick.true_shift      = step_tick && step_cnt == `STEP_TRUE;
    tick.displaced_shift = step_tick && step_cnt == ctrl.distort_count;
    tick.early           = step_tick && step_cnt == `STEP_EARLY;
    tick.load            = step_tick && step_cnt == `STEP_LOAD;
    tick.mid_bit         = step_tick && step_cnt == `STEP_MID;
  end

  // Bit subdivision counter; the half-stop reset restarts the bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_cnt <= `STEP_TRUE;
    end else if (ce_i) begin
      if (!run_control || half_stop_reset) begin
        step_cnt <= `STEP_TRUE;
      end else if (step_tick) begin
        step_cnt <= (step_cnt == `BIT_STEPS - 7'h01) ? `STEP_TRUE
                                                     : step_cnt + 7'h01;
      end
    end
  end

  // Shift pulse source: external stepping blocks both internal paths
  always_comb begin
    if (ctrl.ext_bit_sync) begin
      shift_pulse = ext_step_clk_i && run_control;
    end else if (ctrl.distort_en) begin
      shift_pulse = tick.displaced_shift;
    end else begin
      shift_pulse = tick.true_shift;
    end
  end

  // Detection over the register stages
  assign all_space = (sreg == '0);
  always_comb begin
    if (sync_mode) begin
      last_mark = sreg[`NEXT_LAST] &&
                  (sreg[`NEXT_LAST-1:0] == '0);
    end else begin
      last_mark = ss_mode && sreg[`LAST_STAGE] &&
                  (sreg[`NEXT_LAST:0] == '0);
    end
  end

  // Half-stop counter reset: start-stop, 1.5 stop, running only
  assign half_stop_reset = ss_mode && last_mark && tick.mid_bit &&
                           ctrl.stop_sel == char_shift_pkg::STOP_1_5 &&
                           run_control;

  // Load request flip-flop, updated on the early tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_request <= 1'b0;
    end else if (ce_i && tick.early) begin
      if (all_space || (sync_mode && last_mark)) begin
        load_request <= !rand_mode && !rev_mode;
      end else begin
        load_request <= 1'b0;
      end
    end
  end

  // Load early in the start bit (synchronous: in the last data bit), so characters run back to back
  assign load_strobe = load_request && tick.load &&
                       !rand_mode && !rev_mode;

  assign char_vec = build_char(char_data_i, ctrl.width_sel,
                               ctrl.stop_sel != char_shift_pkg::STOP_1_0,
                               sync_mode);

  // Next register contents for load, shift and pattern feedback
  always_comb begin
    next_sreg = sreg;
    if (load_strobe) begin
      if (sync_mode) begin
        // Last stage keeps the bit on the line; indicator overwritten
        next_sreg = {sreg[`LAST_STAGE], char_vec[`NEXT_LAST:0]};
      end else begin
        next_sreg = char_vec;
      end
    end else if (shift_pulse) begin
      next_sreg = {sreg[`LAST_STAGE-1:0], 1'b0};
      if (rand_mode) begin
        // x^11 + x^9 + 1; an all-Space register is seeded with a Mark
        next_sreg[0] = (sreg[`LAST_STAGE] ^ sreg[`LFSR_TAP]) ||
                       all_space;
      end
      if (rev_mode) begin
        next_sreg[`HALF_LO] = rev_phase;
      end
    end
    if (!run_control) begin
      next_sreg[`LAST_STAGE] = 1'b1;
    end
  end

  // Data register, 11 stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sreg <= '0;
    end else if (ce_i) begin
      sreg <= next_sreg;
    end
  end

  // Sampled shift pulse for the reversals feed: alternates each shift
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rev_phase <= 1'b0;
    end else if (ce_i && shift_pulse) begin
      rev_phase <= !rev_phase;
    end
  end

  // Run control: forced set in free modes; in step modes a step sets it
  // and the character end clears it, the set winning a collision
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_control <= 1'b0;
    end else if (ce_i) begin
      if (free_mode) begin
        run_control <= 1'b1;
      end else if (step_button_i || ext_step_i) begin
        run_control <= 1'b1;
      end else if (char_end_i) begin
        run_control <= 1'b0;
      end
    end
  end

  // Outputs; the serial line is the last stage flip-flop
  assign serial_o          = sreg[`LAST_STAGE];
  assign shift_pulse_o     = shift_pulse;
  assign load_strobe_o     = load_strobe;
  assign last_mark_flag_o  = last_mark;
  assign half_stop_reset_o = half_stop_reset;
  assign run_control_o     = run_control;
  assign run_control_n_o   = !run_control;
  assign timebase_o        = tb_ff;

endmodule

// >>> tb/character_shift_checker.sv
// Port-level assertions for the character shift register control block.
// Assumes ce_i is held high by the bench; bound to the design below.
module character_shift_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        ext_step_clk_i,
  input wire logic        step_button_i,
  input wire logic        ext_step_i,
  input wire logic        char_end_i,
  input wire logic [7:0]  char_data_i,
  input wire logic        serial_o,
  input wire logic        shift_pulse_o,
  input wire logic        load_strobe_o,
  input wire logic        last_mark_flag_o,
  input wire logic        half_stop_reset_o,
  input wire logic        run_control_o,
  input wire logic        run_control_n_o,
  input wire logic        timebase_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking main_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Bus request and its single-cycle answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // Run control turned off and left off long enough to settle
  sequence s_run_stop;
    run_control_o ##1 !run_control_o [*3];
  endsequence

  AST_WB_ANSWER: assert property (s_req |=> s_ack_pulse)
    else $error("bus request not answered by one ack pulse");
  AST_ACK_NEEDS_REQ: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without a request");
  AST_RUN_COMPLEMENT: assert property (run_control_n_o == !run_control_o)
    else $error("run control outputs not complementary");
  AST_SHIFT_NEEDS_RUN: assert property (shift_pulse_o |-> run_control_o)
    else $error("shift pulse while stopped");
  AST_LOAD_ONE_CYCLE: assert property (load_strobe_o |=> !load_strobe_o)
    else $error("load strobe longer than one cycle");
  AST_HALF_STOP_CAUSE: assert property (half_stop_reset_o |->
    last_mark_flag_o && run_control_o)
    else $error("half-stop reset without last mark and run");
  AST_STOPPED_MARK: assert property (s_run_stop |-> serial_o)
    else $error("line not Mark while stopped");
  AST_STOPPED_TIMEBASE: assert property (!run_control_o [*2] |->
    timebase_o && !load_strobe_o)
    else $error("time base not held while stopped");
  AST_STEP_SETS_RUN: assert property ((step_button_i || ext_step_i) && ce_i
    |=> run_control_o)
    else $error("step pulse did not set run control");
  // The line only moves on a shift or a load while running
  AST_SERIAL_QUIET: assert property (run_control_o && $past(run_control_o)
    && !$past(shift_pulse_o) && !$past(load_strobe_o) |-> $stable(serial_o))
    else $error("serial line moved without a shift");
endmodule

bind character_shift_register_control character_shift_checker
  i_character_shift_checker (
  .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_step_clk_i,
  .step_button_i, .ext_step_i, .char_end_i, .char_data_i, .serial_o,
  .shift_pulse_o, .load_strobe_o, .last_mark_flag_o, .half_stop_reset_o,
  .run_control_o, .run_control_n_o, .timebase_o);

// >>> tb/char_line_receiver.sv
// Listener on the serial data line driven by the equipment under test.
// Assumes the line settles on the edge that ends each shift pulse.
module char_line_receiver (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        serial_i,
  input  wire logic        shift_i,
  output logic      [63:0] bits_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic shift_d;

  // Sample one cycle after each shift so the new bit has landed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_d <= 1'b0;
      bits_o  <= '0;
    end else begin
      shift_d <= shift_i;
      if (shift_d) begin
        bits_o <= {bits_o[62:0], serial_i}; // Newest bit at the bottom
      end
    end
  end
endmodule

// >>> tb/test_character_shift_register_control.sv
// Self-checking bench for the character shift register control block.
// Assumes divisor 1 after reset, so one bit lasts 200 clocks.
module test_character_shift_register_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, char_data_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic ext_step_clk_i, step_button_i, ext_step_i, char_end_i, serial_o;
  logic shift_pulse_o, load_strobe_o, last_mark_flag_o, half_stop_reset_o;
  logic run_control_o, run_control_n_o, timebase_o;
  logic [63:0] bits_seen;
  int n_errors, checks, n_cy, n_sh, n_ld, n_hs, n_lm;
  // Formats: control word, shifts and clocks between loads, half-stops
  // The last entry moves every shift to step 10 of the bit
  logic [31:0] fmt_ctl [8] = '{32'h1, 32'h81, 32'h101, 32'h701, 32'h201,
                               32'h8, 32'h88, 32'hA801};
  int fmt_sh [8] = '{7, 8, 8, 11, 8, 5, 5, 7};
  int fmt_cy [8] = '{1400, 1500, 1600, 2200, 1600, 1000, 1000, 1400};
  int fmt_hs [8] = '{0, 1, 0, 0, 0, 0, 0, 0};

  character_shift_register_control i_character_shift_register_control (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_step_clk_i,
    .step_button_i, .ext_step_i, .char_end_i, .char_data_i, .serial_o,
    .shift_pulse_o, .load_strobe_o, .last_mark_flag_o, .half_stop_reset_o,
    .run_control_o, .run_control_n_o, .timebase_o);
  char_line_receiver i_char_line_receiver (.clk_i(clk_i), .rst_i(rst_i),
    .serial_i(serial_o), .shift_i(shift_pulse_o), .bits_o(bits_seen));

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic Wishbone cycle; held until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [7:0] a,
                          input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // No cycle count assumed; only the watchdog ends a lost answer
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask

  task automatic pulse_char_end;
    @(posedge clk_i) char_end_i <= 1'b1;
    @(posedge clk_i) char_end_i <= 1'b0;
  endtask

  // Tally one settled cycle of the combinational pulses
  task automatic tally;
    @(negedge clk_i);
    n_cy++;
    n_sh += int'(shift_pulse_o === 1'b1);
    n_ld += int'(load_strobe_o === 1'b1);
    n_hs += int'(half_stop_reset_o === 1'b1);
    n_lm += int'(last_mark_flag_o === 1'b1);
  endtask

  task automatic run_cycles(input int n);
    {n_cy, n_sh, n_ld, n_hs, n_lm} = '0;
    repeat (n) tally;
  endtask

  // Span from one load to the next; the first load only aligns
  task automatic measure;
    {n_cy, n_ld} = '0;
    while (n_ld == 0 && n_cy < 5000) tally;
    {n_cy, n_sh, n_ld, n_hs, n_lm} = '0;
    while (n_ld == 0 && n_cy < 5000) tally;
    check("load_seen", 32'h1, n_ld);
  endtask

  task automatic test_regs;
    wb_cycle(1'b0, 8'h00, 32'h0);
    check("ctrl", 32'h1, rd);
    wb_cycle(1'b1, 8'h04, 32'h1);
    wb_cycle(1'b0, 8'h04, 32'h0);
    check("divisor", 32'h1, rd);
    wb_cycle(1'b0, 8'h08, 32'h0);
    check("status_run", 32'h1, rd[31]);
    wb_cycle(1'b1, 8'h0C, 32'hFFFFFFFF);
    wb_cycle(1'b0, 8'h0C, 32'h0);
    check("unmapped", 32'h0, rd);
    pulse_char_end;
    @(negedge clk_i);
    check("free_run", 32'h1, run_control_o);
  endtask

  task automatic test_formats;
    for (int i = 0; i < 8; i++) begin
      wb_cycle(1'b1, 8'h00, fmt_ctl[i]);
      measure;
      check("shifts", fmt_sh[i], n_sh);
      check("half_stops", fmt_hs[i], n_hs);
      check("last_mark", 32'h1, n_lm > 0);
      check("clocks", 32'h1, n_cy > fmt_cy[i] - 5 && n_cy < fmt_cy[i] + 5);
      if (i == 0) check("frame", 8'h62, bits_seen[7:0]);
    end
  endtask

  task automatic test_patterns;
    wb_cycle(1'b1, 8'h00, 32'h10);
    run_cycles(4000);
    check("random_loads", 32'h0, n_ld);
    check("random_bits", 32'h1, ^bits_seen[14:0] !== 1'bx
      && bits_seen[14:0] != 15'h0 && bits_seen[14:0] != 15'h7FFF);
    wb_cycle(1'b1, 8'h00, 32'h20);
    run_cycles(4000);
    check("rev_loads", 32'h0, n_ld);
    check("rev_bits", 32'h1, bits_seen[7:0] == 8'h55
      || bits_seen[7:0] == 8'hAA);
  endtask

  task automatic test_ext_sync;
    // Displaced path armed as well; both internal paths must stay blocked
    wb_cycle(1'b1, 8'h00, 32'hA841);
    run_cycles(600);
    check("internal_shifts", 32'h0, n_sh);
    repeat (6) begin
      @(posedge clk_i) ext_step_clk_i <= 1'b1;
      @(negedge clk_i) check("ext_shift", 32'h1, shift_pulse_o);
      @(posedge clk_i) ext_step_clk_i <= 1'b0;
      @(negedge clk_i) check("ext_idle", 32'h0, shift_pulse_o);
      repeat (5) @(posedge clk_i);
    end
  endtask

  task automatic test_step(input logic [31:0] ctl, input logic use_ext);
    wb_cycle(1'b1, 8'h00, ctl);
    pulse_char_end;
    run_cycles(600);
    check("run_off", 32'h0, run_control_o);
    check("run_n", 32'h1, run_control_n_o);
    check("stopped_shifts", 32'h0, n_sh);
    check("steady_mark", 32'h1, serial_o);
    check("timebase", 32'h1, timebase_o);
    @(posedge clk_i) {ext_step_i, step_button_i} <= {use_ext, !use_ext};
    @(posedge clk_i) {ext_step_i, step_button_i} <= 2'h0;
    run_cycles(800);
    check("run_on", 32'h1, run_control_o);
    check("stepping", 32'h1, n_sh > 2);
  endtask

  task automatic print_verdict;
    $display("Errors: %0d, checks: %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Free-running 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Main sequence; inputs are all given a value at time zero
  initial begin
    {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h18;
    {wb_adr_i, wb_sel_i, wb_dat_i, char_data_i} = {8'h0, 4'hF, 32'h0, 8'h03};
    {ext_step_clk_i, step_button_i, ext_step_i, char_end_i} = 4'h0;
    {n_errors, checks} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    test_regs;
    test_formats;
    test_patterns;
    test_ext_sync;
    test_step(32'h2, 1'b0);
    test_step(32'h4, 1'b1);
    print_verdict;
  end

  // Watchdog: 100k cycles, about three times the 35k cycles the tests need
  initial begin
    #800000;
    n_errors++;
    print_verdict;
  end
endmodule
